/* core/core_issue_cfg.svh */
`ifndef CORE_ISSUE_CFG_SVH
`define CORE_ISSUE_CFG_SVH

// ****************************************
// consumer opcodes with a fast load path
// ****************************************
`define FAST_FWD_OPS 16'h8cfc

// ****************************************
// address generation and occupancy
// ****************************************
`define CYC_NONE 4'h0
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2
`define CYC_THREE 4'h3
`define PAIR_REGS 5'h02
`define REG_STEP 5'h01

// ****************************************
// result latencies
// ****************************************
`define LAT_NONE 3'h0
`define LAT_TWO 3'h2
`define LAT_THREE 3'h3
`define LAT_FOUR 3'h4
`define LAT_FIVE 3'h5
`endif

/* core/core_issue_pkg.sv */
package core_issue_pkg;
  typedef enum logic [3:0] {
    OP_DP, OP_BRANCH_IMM, OP_LOAD_WORD, OP_LOAD_BYTEHALF, OP_LOAD_MULTI, OP_LOAD_DOUBLE,
    OP_STORE_SINGLE, OP_STORE_MULTI, OP_STORE_DOUBLE, OP_MUL_LONG, OP_MUL_HALF,
    OP_MUL_WORD, OP_MUL_HALF_LONG, OP_SYSTEM
  } opClass_t;

  typedef enum logic [4:0] {
    SYS_NONE, SYS_SVC, SYS_SMC, SYS_BKPT, SYS_PSR_CTRL, SYS_PSR_PLAIN, SYS_CPS,
    SYS_SETEND, SYS_CP_WRITE, SYS_ISB, SYS_DMB, SYS_DBG_READ, SYS_WFE, SYS_WFI,
    SYS_SEV, SYS_CLREX, SYS_DSB, SYS_SPSR_WRITE
  } sysOp_t;

  typedef struct packed {
    opClass_t opClass;
    sysOp_t sysOp;
    logic [3:0] dpOp;
    logic regShiftOffset;
    logic [4:0] regCount;
    logic aligned64;
    logic writesPc;
    logic setsFlags;
    logic excReturn;
    logic prefetchAbort;
    logic undefined;
  } issueReq_t;

  typedef struct packed {
    logic valid;
    logic [3:0] dpOp;
    logic operandShifted;
  } consumer_t;

  typedef struct packed {
    logic regsPending;
    logic flagsPending;
    logic memPending;
  } older_t;

  typedef struct packed {
    logic [3:0] agenCycles;
    logic [3:0] occupy;
    logic [2:0] latFirst;
    logic [2:0] latSecond;
    logic fastFwd;
  } timing_t;

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_DRAIN = 3'b010,
    ST_BUSY = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic [3:0] cnt;
    logic memOnly;
    logic ready;
    logic taken;
    logic serial;
    timing_t timing;
  } state_t;
endpackage

/* core/core_issue_timing.sv */
`include "core_issue_cfg.svh"

module core_issue_timing import core_issue_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic issueValid,
  input wire issueReq_t issueReq,
  input wire consumer_t nextConsumer,
  input wire older_t older,
  output logic issueReady,
  output logic issueTaken,
  output logic serializing,
  output timing_t timing
);

  // ****************************************
  // decode helpers
  // ****************************************

  // address cycles for a register list: pairs only on aligned addresses
  function automatic logic [3:0] agenForCount(input logic [4:0] n, input logic aligned);
    logic [4:0] half;
    // aligned rounds up, else floor plus one
    half = aligned ? ((n + `REG_STEP) >> 1) : ((n >> 1) + `REG_STEP);
    return half[3:0];
  endfunction

  // instructions that must see all older updates before they run
  function automatic logic isSerializing(input issueReq_t r);
    logic s;
    s = 1'b0;
    if (r.prefetchAbort || r.undefined) begin
      s = 1'b1;
    end
    // data processing to pc with flags
    if (r.opClass == OP_DP && r.writesPc && r.setsFlags) begin
      s = 1'b1;
    end
    if (r.excReturn) begin
      s = 1'b1;
    end
    if (r.opClass == OP_SYSTEM) begin
      unique case (r.sysOp)
        SYS_SVC, SYS_SMC, SYS_BKPT: s = 1'b1;
        SYS_PSR_CTRL, SYS_CPS, SYS_SETEND: s = 1'b1;
        SYS_CP_WRITE, SYS_DBG_READ, SYS_WFE, SYS_WFI, SYS_SEV: s = 1'b1;
        SYS_CLREX, SYS_DSB, SYS_SPSR_WRITE: s = 1'b1;
        default: s = s;
      endcase
    end
    return s;
  endfunction

  // fast path only for listed consumers reading an unshifted operand
  function automatic logic fastEligible(input consumer_t c);
    logic [15:0] mask;
    mask = `FAST_FWD_OPS;
    return c.valid && mask[c.dpOp] && !c.operandShifted;
  endfunction

  // cycle and latency figures for one instruction
  function automatic timing_t timingOf(input issueReq_t r, input logic fast);
    timing_t t;
    logic [4:0] n;
    t.agenCycles = `CYC_NONE;
    t.occupy = `CYC_ONE;
    t.latFirst = `LAT_NONE;
    t.latSecond = `LAT_NONE;
    t.fastFwd = 1'b0;
    n = r.regCount;
    unique case (r.opClass)
      OP_LOAD_WORD: begin
        t.agenCycles = `CYC_ONE;
        t.fastFwd = fast;
        if (r.regShiftOffset) begin
          t.latFirst = fast ? `LAT_THREE : `LAT_FOUR;
        end else begin
          t.latFirst = fast ? `LAT_TWO : `LAT_THREE;
        end
      end
      OP_LOAD_BYTEHALF: begin
        t.agenCycles = `CYC_TWO;
        t.fastFwd = fast;
        if (r.regShiftOffset) begin
          t.latFirst = fast ? `LAT_FOUR : `LAT_FIVE;
        end else begin
          t.latFirst = fast ? `LAT_THREE : `LAT_FOUR;
        end
      end
      OP_LOAD_MULTI, OP_LOAD_DOUBLE: begin
        // doubleword and rfe as two registers
        if (r.opClass == OP_LOAD_DOUBLE) begin
          n = `PAIR_REGS;
        end
        t.agenCycles = agenForCount(n, r.aligned64);
        t.fastFwd = fast;
        t.latFirst = fast ? `LAT_TWO : `LAT_THREE;
      end
      OP_STORE_MULTI, OP_STORE_DOUBLE: begin
        if (r.opClass == OP_STORE_DOUBLE) begin
          n = `PAIR_REGS;
        end
        t.agenCycles = agenForCount(n, r.aligned64);
      end
      OP_STORE_SINGLE: t.agenCycles = `CYC_ONE;
      OP_MUL_LONG: begin
        t.occupy = `CYC_THREE;
        t.latFirst = `LAT_FOUR;
        t.latSecond = `LAT_FIVE;
      end
      OP_MUL_HALF: begin
        t.latFirst = `LAT_THREE;
      end
      OP_MUL_WORD: begin
        t.occupy = `CYC_TWO;
        t.latFirst = `LAT_FOUR;
      end
      OP_MUL_HALF_LONG: begin
        t.occupy = `CYC_TWO;
        t.latFirst = `LAT_THREE;
        t.latSecond = `LAT_FOUR;
      end
      OP_BRANCH_IMM: t.occupy = `CYC_NONE;
      OP_DP, OP_SYSTEM: t.occupy = `CYC_ONE;
      default: t.occupy = `CYC_ONE;
    endcase
    // memory ops hold the unit for their address cycles
    if (t.agenCycles != `CYC_NONE) begin
      t.occupy = t.agenCycles;
    end
    return t;
  endfunction

  // ****************************************
  // state
  // ****************************************
  state_t st_r;
  state_t st_nxt;

  // next-state logic: accept, drain for serializing, hold for occupancy
  always_comb begin
    logic take;
    logic ser;
    logic drained;
    take = 1'b0;
    ser = 1'b0;
    drained = 1'b0;
    st_nxt = st_r;
    st_nxt.taken = 1'b0;
    unique case (st_r.fsm)
      ST_READY: begin
        take = issueValid && st_r.ready;
        if (take) begin
          ser = isSerializing(issueReq);
          st_nxt.taken = 1'b1;
          st_nxt.serial = ser;
          // pc writes keep their own class timing
          st_nxt.timing = timingOf(issueReq, fastEligible(nextConsumer));
          st_nxt.memOnly = 1'b0;
          if (ser) begin
            // hold issue until older work drains
            st_nxt.fsm = ST_DRAIN;
            st_nxt.ready = 1'b0;
          end else if (issueReq.opClass == OP_SYSTEM && issueReq.sysOp == SYS_DMB) begin
            // barrier waits on memory ops only
            st_nxt.fsm = ST_DRAIN;
            st_nxt.memOnly = 1'b1;
            st_nxt.ready = 1'b0;
          end else begin
            st_nxt.cnt = st_nxt.timing.occupy;
            if (st_nxt.timing.occupy > `CYC_ONE) begin
              st_nxt.fsm = ST_BUSY;
              st_nxt.ready = 1'b0;
            end
          end
        end
      end
      ST_DRAIN: begin
        // a barrier ignores pending register writes, which can hide its cost
        drained = st_r.memOnly ? !older.memPending
                               : !(older.regsPending || older.flagsPending || older.memPending);
        if (drained) begin
          st_nxt.cnt = st_r.timing.occupy;
          if (st_r.timing.occupy > `CYC_ONE) begin
            st_nxt.fsm = ST_BUSY;
          end else begin
            st_nxt.fsm = ST_READY;
            st_nxt.ready = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        // take cycle counts as the first occupied cycle
        st_nxt.cnt = st_r.cnt - `CYC_ONE;
        if (st_r.cnt == `CYC_TWO) begin
          st_nxt.fsm = ST_READY;
          st_nxt.ready = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '{fsm: ST_READY, cnt: `CYC_NONE, memOnly: 1'b0, ready: 1'b1, taken: 1'b0,
                serial: 1'b0, timing: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign issueReady = st_r.ready;
  assign issueTaken = st_r.taken;
  assign serializing = st_r.serial;
  assign timing = st_r.timing;

endmodule

/* testbench/core_issue_timing_asserts.sv */
module core_issue_timing_asserts import core_issue_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic issueValid,
  input wire issueReq_t issueReq,
  input wire consumer_t nextConsumer,
  input wire older_t older,
  input wire logic issueReady,
  input wire logic issueTaken,
  input wire logic serializing,
  input wire timing_t timing
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clocking and reset are stated once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // issue timing checks
  // ****************************************
  a_take_pulse: assert property (issueValid && issueReady |=> issueTaken) else $error("take not pulsed");
  a_long_mul: assert property (issueTaken && !serializing && timing.occupy == 4'h3
    |-> !issueReady ##1 !issueReady ##1 issueReady) else $error("three cycle stall wrong");
  a_word_mul: assert property (issueTaken && !serializing && timing.occupy == 4'h2
    |-> !issueReady ##1 issueReady) else $error("two cycle stall wrong");
  a_multi_agen: assert property (issueTaken && $past(issueReq.opClass) == OP_LOAD_MULTI |->
    timing.agenCycles == 4'($past(issueReq.aligned64) ? ($past(issueReq.regCount) + 5'h01) >> 1 :
    ($past(issueReq.regCount) >> 1) + 5'h01)) else $error("multiple agen count");
  a_multi_lat: assert property (issueTaken && $past(issueReq.opClass) == OP_LOAD_MULTI
    |-> timing.latFirst == (timing.fastFwd ? 3'h2 : 3'h3)) else $error("multiple latency");
  a_fast_cond: assert property (issueTaken && timing.fastFwd
    |-> $past(nextConsumer.valid) && !$past(nextConsumer.operandShifted)) else $error("fast path misused");
  a_ser_hold: assert property (serializing && !issueReady && (older.regsPending || older.flagsPending)
    |=> !issueReady) else $error("serial drain early");
  a_branch_free: assert property (issueTaken && !serializing && $past(issueReq.opClass) == OP_BRANCH_IMM
    |-> timing.occupy == 4'h0 && issueReady) else $error("branch used cycles");
endmodule

/* testbench/core_issue_timing_tb.sv */
module core_issue_timing_tb import core_issue_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, srst, issueValid, issueReady, issueTaken, serializing;
  issueReq_t issueReq;
  consumer_t nextConsumer;
  older_t older;
  timing_t timing;
  int mismatches, cmp_count, cycles;
  logic [31:0] rnd;
  issueReq_t r;
  consumer_t c;
  core_issue_timing core_issue_timing_inst (.core_clk(core_clk), .srst(srst), .issueValid(issueValid),
    .issueReq(issueReq), .nextConsumer(nextConsumer), .older(older), .issueReady(issueReady),
    .issueTaken(issueTaken), .serializing(serializing), .timing(timing));
  // ****************************************
  // clock, ceiling, helpers
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // a hung handshake still reaches the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic expS(issueReq_t q);
    return q.prefetchAbort || q.undefined || (q.opClass == OP_DP && q.writesPc && q.setsFlags) ||
      (q.excReturn && q.opClass inside {OP_LOAD_MULTI, OP_LOAD_DOUBLE}) ||
      (q.opClass == OP_SYSTEM && !(q.sysOp inside {SYS_NONE, SYS_PSR_PLAIN, SYS_ISB, SYS_DMB}));
  endfunction
  // doubles count as two registers; fast path lowers a load latency by one
  function automatic timing_t expT(issueReq_t q, consumer_t k);
    logic [4:0] n;
    logic [3:0] m;
    logic [2:0] lo;
    logic f;
    n = q.opClass inside {OP_LOAD_DOUBLE, OP_STORE_DOUBLE} ? 5'h02 : q.regCount;
    m = 4'(q.aligned64 ? (n + 5'h01) >> 1 : (n >> 1) + 5'h01);
    f = k.valid && !k.operandShifted && (k.dpOp inside {[4'h2:4'h7], 4'ha, 4'hb, 4'hf});
    lo = 3'h3 - 3'(f) + 3'(q.regShiftOffset && q.opClass inside {OP_LOAD_WORD, OP_LOAD_BYTEHALF});
    case (q.opClass)
      OP_LOAD_WORD: return '{4'h1, 4'h1, lo, 3'h0, f};
      OP_LOAD_BYTEHALF: return '{4'h2, 4'h2, lo + 3'h1, 3'h0, f};
      OP_LOAD_MULTI, OP_LOAD_DOUBLE: return '{m, m, lo, 3'h0, f};
      OP_STORE_SINGLE: return '{4'h1, 4'h1, 3'h0, 3'h0, 1'b0};
      OP_STORE_MULTI, OP_STORE_DOUBLE: return '{m, m, 3'h0, 3'h0, 1'b0};
      OP_MUL_LONG: return '{4'h0, 4'h3, 3'h4, 3'h5, 1'b0};
      OP_MUL_HALF: return '{4'h0, 4'h1, 3'h3, 3'h0, 1'b0};
      OP_MUL_WORD: return '{4'h0, 4'h2, 3'h4, 3'h0, 1'b0};
      OP_MUL_HALF_LONG: return '{4'h0, 4'h2, 3'h3, 3'h4, 1'b0};
      OP_BRANCH_IMM: return '0;
      default: return '{4'h0, 4'h1, 3'h0, 3'h0, 1'b0};
    endcase
  endfunction
  task automatic check(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // pending levels stand from before the take; hold expects a stall until they clear
  task automatic issue(issueReq_t q, consumer_t k, older_t p, logic hold);
    int n;
    timing_t e;
    n = 0;
    e = expT(q, k);
    while (issueReady !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    older = p;
    issueValid = 1'b1;
    issueReq = q;
    nextConsumer = k;
    @(negedge core_clk);
    issueValid = 1'b0;
    check(16'(issueTaken), 16'h1);
    check(16'(timing), 16'(expT(q, k)));
    check(16'(serializing), 16'(expS(q)));
    if (hold) begin
      repeat (3) begin
        @(negedge core_clk);
        check(16'(issueReady), 16'h0);
      end
      older = '0;
    end
    n = 0;
    while (issueReady !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    if (expS(q) || p != '0) check(16'(issueReady), 16'h1);
    else check(16'(n), 16'(e.occupy > 4'h1 ? e.occupy - 4'h1 : 4'h0));
    older = '0;
    // one idle edge so the next call never reassigns valid in this time step
    @(negedge core_clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {cycles, mismatches, cmp_count} = '0;
    rnd = 32'hda39;
    {srst, issueValid, issueReq, nextConsumer, older} = '0;
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    check(16'({issueReady, issueTaken}), 16'h2);
    check(16'({serializing, timing}), 16'h0);
    r = '0;
    c = '{1'b1, 4'h4, 1'b0};
    r.regCount = 5'h10;
    r.opClass = OP_LOAD_MULTI;
    issue(r, c, '0, 1'b0);
    r.aligned64 = 1'b1;
    issue(r, c, '0, 1'b0);
    r.opClass = OP_STORE_MULTI;
    issue(r, c, '0, 1'b0);
    $display("corner cases done");
    r = '0;
    r.opClass = OP_SYSTEM;
    for (int i = 0; i < 18; i++) begin
      r.sysOp = sysOp_t'(i);
      issue(r, c, r.sysOp == SYS_DMB ? 3'b001 : (expS(r) ? 3'b110 : 3'b000), r.sysOp == SYS_DMB || expS(r));
    end
    r.sysOp = SYS_DMB;
    issue(r, c, 3'b100, 1'b0);
    for (int i = 0; i < 5; i++) begin
      r = '0;
      r.opClass = i < 3 ? OP_DP : (i == 3 ? OP_LOAD_MULTI : OP_LOAD_DOUBLE);
      {r.prefetchAbort, r.undefined, r.writesPc, r.setsFlags, r.excReturn} = {i == 0, i == 1, i == 2, i == 2, i > 2};
      issue(r, c, 3'b100, 1'b1);
    end
    $display("serializing cases done");
    for (int i = 0; i < 300; i++) begin
      rnd = lfsr(lfsr(rnd));
      r = issueReq_t'(rnd[24:0]);
      r.opClass = opClass_t'(rnd[28:25] % 4'hd);
      r.sysOp = SYS_NONE;
      r.regCount = 5'(rnd[3:0]) + 5'h01;
      {r.excReturn, r.prefetchAbort, r.undefined} = 3'b000;
      rnd = lfsr(lfsr(rnd));
      c = consumer_t'(rnd[5:0]);
      issue(r, c, '0, 1'b0);
    end
    $display("random cases done");
    test_done();
  end
endmodule
bind core_issue_timing core_issue_timing_asserts core_issue_timing_asserts_inst (.core_clk(core_clk), .srst(srst),
  .issueValid(issueValid), .issueReq(issueReq), .nextConsumer(nextConsumer), .older(older),
  .issueReady(issueReady), .issueTaken(issueTaken), .serializing(serializing), .timing(timing));
